// ===== design/cts_timing_map.vh
// Cycle-count and encoding constants for the instruction timing sequencer.
// Assumes it is included by the sequencer module only; definitions only.
`ifndef CTS_TIMING_MAP_VH
`define CTS_TIMING_MAP_VH

// Addressing mode codes (2 bits)
`define CTS_AM_REG 2'h0
`define CTS_AM_IND 2'h1
`define CTS_AM_INC 2'h2
`define CTS_AM_IDX 2'h3

// Instruction classes (3 bits)
`define CTS_CL_TWO 3'h0
`define CTS_CL_SWAP 3'h1
`define CTS_CL_PUSH 3'h2
`define CTS_CL_CALL 3'h3
`define CTS_CL_JUMP 3'h4
`define CTS_CL_RETURN_FROM_INTERRUPT_OP 3'h5
`define CTS_CL_RET 3'h6

// Cycle counts (4 bits)
`define CTS_C1 4'h1
`define CTS_C2 4'h2
`define CTS_C3 4'h3
`define CTS_C4 4'h4
`define CTS_C5 4'h5
`define CTS_C6 4'h6
`define CTS_IRQ_ENTRY 4'h6
`define CTS_RETURN_FROM_INTERRUPT_OP_CYC 4'h5
`define CTS_JUMP_CYC 4'h2
`define CTS_LPM_EXTRA 4'h2

// Addresses and opcodes
`define CTS_WORD_STEP 16'h0002
`define CTS_TIMER_VEC 16'hffe2
`define CTS_IND_JUMP_OP 16'h4020
`define CTS_PC_REG 4'h0

`endif

// ===== design/cts_sequencer.v
// Instruction timing and control-flow sequencer of a small 16-bit core.
// Assumes a one-word-per-cycle memory port answering reads in the same cycle
// (rdData valid while memRd high) and a decoder that presents class and modes.
// Summary of operation
// - Two-operand cycles by source and destination mode
// - Register destination PC adds one cycle, except with indexed source
// - Register single-operand: 1, push 3, call 4
// - Single-operand counts for indirect, increment, indexed
// - Every jump-class instruction takes exactly two cycles; the 4020h indirect jump takes three
// - Interrupt pushes PC then status, six cycles
// - Interrupt return restores both, five cycles
// - Deep low-power wake adds two cycles
// - Interrupt pushes only below stack pointer
// - Return address on top, arguments above it
// - Call pushes next address; return pops top
// - Opcode 4020h jumps through following word
// - Timer interrupt vector fetched from ffe2h
`timescale 1ns/1ps
`default_nettype none
`include "cts_timing_map.vh"

module cts_sequencer (
  input wire ref_clk,
  input wire rst,
  input wire start, // Decoded instruction ready (same-clock pulse)
  input wire [2:0] instrClass,
  input wire [1:0] srcMode,
  input wire [1:0] dstMode, // Only REG vs IDX matter for two-operand
  input wire [3:0] dstReg,
  input wire [15:0] opcode,
  input wire [15:0] nextPc, // Address following the whole instruction
  input wire [15:0] branchTarget, // Call or jump target
  input wire [15:0] autoIncAddr, // Register used by @Rn+
  input wire [15:0] statusIn, // Current status_word
  input wire irqReq, // Enabled timer interrupt (asynchronous pin)
  input wire deepSleep, // Core in low-power mode 3 or 4
  input wire [15:0] rdData,
  output reg busy,
  output reg instrStart, // One-cycle pulse at each instruction start
  output reg [3:0] cycleCount, // Count chosen for the current instruction
  output reg [15:0] pc,
  output reg [15:0] stack_pointer_reg,
  output reg [15:0] status_word,
  output reg [15:0] autoIncNext,
  output reg memRd,
  output reg memWr,
  output reg [15:0] memAddr,
  output reg [15:0] wrData
);

  localparam ST_IDLE = 2'h0; // Waiting for work
  localparam ST_RUN = 2'h1; // Counting cycles of an instruction
  localparam ST_IRQ = 2'h2; // Interrupt entry sequence
  localparam ST_RTI = 2'h3; // Interrupt return sequence

  reg [1:0] state;
  reg [3:0] left; // Cycles still to spend
  reg [3:0] step; // Cycle index inside a sequence
  reg [2:0] curClass; // Class latched at start
  reg irqMeta, irqSync; // Interrupt request synchroniser
  reg [3:0] cnt; // Combinational lookup result

  // Cycle-count lookup from class and modes
  always @* begin
    cnt = `CTS_C1;
    case (instrClass)
      `CTS_CL_TWO: begin
        case (srcMode)
          `CTS_AM_REG: cnt = (dstMode == `CTS_AM_REG) ? `CTS_C1 : `CTS_C4;
          `CTS_AM_IDX: cnt = (dstMode == `CTS_AM_REG) ? `CTS_C3 : `CTS_C6;
          default: cnt = (dstMode == `CTS_AM_REG) ? `CTS_C2 : `CTS_C5;
        endcase
        // PC destination costs a pipeline refill only in the short cases
        if (dstMode == `CTS_AM_REG && dstReg == `CTS_PC_REG && srcMode != `CTS_AM_IDX)
          cnt = cnt + `CTS_C1;
      end
      `CTS_CL_SWAP: begin
        case (srcMode)
          `CTS_AM_REG: cnt = `CTS_C1;
          `CTS_AM_IDX: cnt = `CTS_C4;
          default: cnt = `CTS_C3;
        endcase
      end
      `CTS_CL_PUSH: begin
        case (srcMode)
          `CTS_AM_REG: cnt = `CTS_C3;
          `CTS_AM_IDX: cnt = `CTS_C5;
          default: cnt = `CTS_C4;
        endcase
      end
      `CTS_CL_CALL: begin
        case (srcMode)
          `CTS_AM_REG: cnt = `CTS_C4;
          `CTS_AM_IND: cnt = `CTS_C4;
          default: cnt = `CTS_C5;
        endcase
      end
      `CTS_CL_JUMP: cnt = `CTS_JUMP_CYC;
      `CTS_CL_RETURN_FROM_INTERRUPT_OP: cnt = `CTS_RETURN_FROM_INTERRUPT_OP_CYC;
      `CTS_CL_RET: cnt = `CTS_C3;
      default: cnt = `CTS_C1;
    endcase
  end

  // Interrupt pin crosses in through two flops before use
  always @(posedge ref_clk) begin
    if (rst) begin
      irqMeta <= 1'b0;
      irqSync <= 1'b0;
    end else begin
      irqMeta <= irqReq;
      irqSync <= irqMeta;
    end
  end

  // Main sequencer; stack work is spread over the counted cycles
  always @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      left <= 4'h0;
      step <= 4'h0;
      curClass <= `CTS_CL_TWO;
      busy <= 1'b0;
      instrStart <= 1'b0;
      cycleCount <= 4'h0;
      pc <= 16'h0000;
      stack_pointer_reg <= 16'h0000;
      status_word <= 16'h0000;
      autoIncNext <= 16'h0000;
      memRd <= 1'b0;
      memWr <= 1'b0;
      memAddr <= 16'h0000;
      wrData <= 16'h0000;
    end else begin
      instrStart <= 1'b0;
      memRd <= 1'b0;
      memWr <= 1'b0;
      case (state)
        ST_IDLE: begin
          step <= 4'h0;
          if (irqSync) begin
            // Interrupts taken only between instructions
            state <= ST_IRQ;
            busy <= 1'b1;
            cycleCount <= deepSleep ? `CTS_IRQ_ENTRY + `CTS_LPM_EXTRA
                                    : `CTS_IRQ_ENTRY;
            left <= deepSleep ? `CTS_IRQ_ENTRY + `CTS_LPM_EXTRA : `CTS_IRQ_ENTRY;
            instrStart <= 1'b1;
          end else if (start) begin
            busy <= 1'b1;
            instrStart <= 1'b1;
            cycleCount <= cnt;
            left <= cnt;
            curClass <= instrClass;
            state <= (instrClass == `CTS_CL_RETURN_FROM_INTERRUPT_OP) ? ST_RTI : ST_RUN;
            if (srcMode == `CTS_AM_INC) begin
              memRd <= 1'b1;
              memAddr <= autoIncAddr; // Read through the register first
              autoIncNext <= autoIncAddr + `CTS_WORD_STEP;
            end
            if (opcode == `CTS_IND_JUMP_OP) begin
              memRd <= 1'b1;
              memAddr <= pc + `CTS_WORD_STEP;
            end
            if (instrClass == `CTS_CL_PUSH) begin
              // No operand datapath here: statusIn stands in for the pushed word
              stack_pointer_reg <= stack_pointer_reg - `CTS_WORD_STEP;
              memWr <= 1'b1;
              memAddr <= stack_pointer_reg - `CTS_WORD_STEP;
              wrData <= statusIn;
            end
            if (instrClass == `CTS_CL_CALL) begin
              stack_pointer_reg <= stack_pointer_reg - `CTS_WORD_STEP;
              memWr <= 1'b1;
              memAddr <= stack_pointer_reg - `CTS_WORD_STEP;
              wrData <= nextPc;
            end
            if (instrClass == `CTS_CL_RET) begin
              memRd <= 1'b1;
              memAddr <= stack_pointer_reg;
            end
          end else begin
            busy <= 1'b0;
          end
        end
        ST_RUN: begin
          step <= step + 4'h1;
          if (step == 4'h0) begin
            // Control-flow outcome lands one cycle after start
            case (curClass)
              `CTS_CL_CALL, `CTS_CL_JUMP: pc <= branchTarget;
              `CTS_CL_RET: begin
                pc <= rdData;
                stack_pointer_reg <= stack_pointer_reg + `CTS_WORD_STEP;
              end
              default: pc <= (opcode == `CTS_IND_JUMP_OP) ? rdData : nextPc;
            endcase
          end
          if (left <= 4'h1) begin
            state <= ST_IDLE;
            busy <= 1'b0;
          end else begin
            left <= left - 4'h1;
          end
        end
        ST_IRQ: begin
          step <= step + 4'h1;
          left <= left - 4'h1;
          case (step)
            4'h0: begin
              // Push below the pointer so the top word survives
              stack_pointer_reg <= stack_pointer_reg - `CTS_WORD_STEP;
              memWr <= 1'b1;
              memAddr <= stack_pointer_reg - `CTS_WORD_STEP;
              wrData <= pc;
            end
            4'h1: begin
              stack_pointer_reg <= stack_pointer_reg - `CTS_WORD_STEP;
              memWr <= 1'b1;
              memAddr <= stack_pointer_reg - `CTS_WORD_STEP;
              wrData <= status_word;
            end
            4'h2: begin
              memRd <= 1'b1;
              memAddr <= `CTS_TIMER_VEC;
            end
            4'h3: pc <= rdData;
            default: ;
          endcase
          if (left <= 4'h1) begin
            state <= ST_IDLE;
            busy <= 1'b0;
          end
        end
        ST_RTI: begin
          step <= step + 4'h1;
          left <= left - 4'h1;
          case (step)
            4'h0: begin
              memRd <= 1'b1;
              memAddr <= stack_pointer_reg;
            end
            4'h1: begin
              status_word <= rdData;
              stack_pointer_reg <= stack_pointer_reg + `CTS_WORD_STEP;
              memRd <= 1'b1;
              memAddr <= stack_pointer_reg + `CTS_WORD_STEP;
            end
            4'h2: begin
              pc <= rdData;
              stack_pointer_reg <= stack_pointer_reg + `CTS_WORD_STEP;
            end
            default: ;
          endcase
          if (left <= 4'h1) begin
            state <= ST_IDLE;
            busy <= 1'b0;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // cts_sequencer
`default_nettype wire

// ===== tb/cts_seq_chk.sv
// Port checks for the timing sequencer.
// Assumes a bind onto cts_sequencer; one clock, reset high.
`timescale 1ns/1ps
`default_nettype none
module cts_seq_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic irqReq,
  input wire logic deepSleep,
  input wire logic busy,
  input wire logic instrStart,
  input wire logic memRd,
  input wire logic memWr,
  input wire logic [2:0] instrClass,
  input wire logic [1:0] srcMode,
  input wire logic [1:0] dstMode,
  input wire logic [3:0] dstReg,
  input wire logic [3:0] cycleCount,
  input wire logic [15:0] nextPc,
  input wire logic [15:0] statusIn,
  input wire logic [15:0] rdData,
  input wire logic [15:0] pc,
  input wire logic [15:0] stack_pointer_reg,
  input wire logic [15:0] memAddr,
  input wire logic [15:0] wrData
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [3:0] n; // Busy cycles seen so far
  always @(posedge ref_clk) n <= (rst || !busy) ? 4'h0 : n + 4'h1;
  // Count from class and mode
  function automatic logic [3:0] ex(logic [2:0] c, logic [1:0] s, d, logic [3:0] r);
    case (c)
      3'h0: ex = (s == 2'h0 ? 4'h1 : s == 2'h3 ? 4'h3 : 4'h2)
        + (d == 2'h0 ? {3'h0, r == 4'h0 && s != 2'h3} : 4'h3);
      3'h1: ex = s == 2'h0 ? 4'h1 : s == 2'h3 ? 4'h4 : 4'h3;
      3'h2: ex = s == 2'h0 ? 4'h3 : s == 2'h3 ? 4'h5 : 4'h4;
      3'h3: ex = s[1] ? 4'h5 : 4'h4;
      3'h4: ex = 4'h2;
      3'h5: ex = 4'h5;
      default: ex = 4'h3; // Return: designer's figure
    endcase
  endfunction
  // Idle decode taken with no interrupt request on the pin; in the design a pending interrupt wins over start
  sequence go; start && !busy && !irqReq; endsequence
  // Interrupt entry: an instruction start that no start request asked for
  sequence irq_go; !start ##1 instrStart; endsequence
  sequence irq_push; memWr && wrData == $past(pc)
    && memAddr == $past(stack_pointer_reg) - 16'h2
    ##1 memWr && memAddr == $past(memAddr) - 16'h2; endsequence
  sequence irq_vec; memRd && memAddr == 16'hffe2 ##1 pc == $past(rdData); endsequence
  cyc_table_a:
    assert property (go |=> instrStart && cycleCount == ex($past(instrClass),
      $past(srcMode), $past(dstMode), $past(dstReg))) else $error("count off table");
  busy_len_a:
    assert property ($fell(busy) |-> n == cycleCount) else $error("busy length");
  jump_cyc_a:
    assert property (go and instrClass == 3'h4 |=> cycleCount == 4'h2) else $error("jump");
  return_from_interrupt_op_cyc_a:
    assert property (go and instrClass == 3'h5 |=> cycleCount == 4'h5) else $error("return_from_interrupt_op");
  start_pulse_a:
    assert property (instrStart |=> !instrStart) else $error("start pulse");
  irq_wait_a:
    assert property ($rose(irqReq) && !busy |-> ##[1:4] instrStart
      && cycleCount == (deepSleep ? 4'h8 : 4'h6)) else $error("irq latency");
  irq_entry_a:
    assert property (irq_go |=> irq_push ##1 irq_vec) else $error("irq entry");
  push_slot_a:
    assert property (go and instrClass == 3'h2 |=> memWr && wrData == $past(statusIn)
      && memAddr == $past(stack_pointer_reg) - 16'h2) else $error("push slot");
  call_push_a:
    assert property (go and instrClass == 3'h3 && srcMode == 2'h0 |=> memWr
      && wrData == $past(nextPc) && memAddr == $past(stack_pointer_reg) - 16'h2)
      else $error("call push");
endmodule // cts_seq_chk
`default_nettype wire

// ===== tb/cts_mem.sv
// Code and stack memory beside the sequencer.
// Assumes reads are answered while memRd is high.
`timescale 1ns/1ps
`default_nettype none
module cts_mem (
  input wire logic ref_clk,
  input wire logic memRd,
  input wire logic memWr,
  input wire logic [15:0] memAddr,
  input wire logic [15:0] wrData,
  output wire logic [15:0] rdData
);
  logic [15:0] m [0:65535]; // Full 64K word store
  logic [15:0] last = 16'h0; // Last word handed out
  // Released bus shows the inverse, so a late sample cannot pass
  assign rdData = memRd ? m[memAddr] : ~last;
  always @(posedge ref_clk) begin
    if (memWr) m[memAddr] <= wrData;
    if (memRd) last <= rdData;
  end
endmodule // cts_mem
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the timing sequencer.
// Assumes checker and memory model compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, w) begin checked++; if ((g) !== (w)) begin badCount++; \
  $display("mismatch %0t got %0h want %0h", $time, g, w); end end
module tb;
  logic ref_clk = 1'b0; // 4 ns period
  logic rst = 1'b1;
  logic start = 1'b0;
  logic irqReq = 1'b0;
  logic deepSleep = 1'b0;
  logic [2:0] instrClass = 3'h0;
  logic [1:0] srcMode = 2'h0, dstMode = 2'h0;
  logic [3:0] dstReg = 4'h1; // Not the program counter by default
  logic [15:0] opcode = 16'h0, nextPc = 16'h0104, branchTarget = 16'h0180;
  logic [15:0] autoIncAddr = 16'h0220, statusIn = 16'h0008;
  wire logic busy, instrStart, memRd, memWr;
  wire logic [3:0] cycleCount;
  wire logic [15:0] rdData, pc, stack_pointer_reg, status_word, autoIncNext, memAddr, wrData;
  int badCount = 0, checked = 0;
  cts_sequencer DUT (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(start),
    .instrClass(instrClass),
    .srcMode(srcMode),
    .dstMode(dstMode),
    .dstReg(dstReg),
    .opcode(opcode),
    .nextPc(nextPc),
    .branchTarget(branchTarget),
    .autoIncAddr(autoIncAddr),
    .statusIn(statusIn),
    .irqReq(irqReq),
    .deepSleep(deepSleep),
    .rdData(rdData),
    .busy(busy),
    .instrStart(instrStart),
    .cycleCount(cycleCount),
    .pc(pc),
    .stack_pointer_reg(stack_pointer_reg),
    .status_word(status_word),
    .autoIncNext(autoIncNext),
    .memRd(memRd),
    .memWr(memWr),
    .memAddr(memAddr),
    .wrData(wrData)
  );
  cts_mem mem (
    .ref_clk(ref_clk),
    .memRd(memRd),
    .memWr(memWr),
    .memAddr(memAddr),
    .wrData(wrData),
    .rdData(rdData)
  );
  always #2 ref_clk = ~ref_clk;
  task automatic stopTest;
    $display("checked %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Busy cycles of one instruction; bounded so a hang ends the run
  task automatic waitDone(output int n);
    int k;
    n = 0;
    for (k = 0; k < 20; k++) begin
      if (busy === 1'b1) n++;
      else if (n > 0) break;
      @(negedge ref_clk);
    end
    if (k == 20) begin
      badCount++;
      stopTest();
    end
  endtask
  task automatic run(input logic [2:0] c, input logic [1:0] s, d, input logic [3:0] r, e);
    int n;
    @(negedge ref_clk);
    {instrClass, srcMode, dstMode, dstReg, start} = {c, s, d, r, 1'b1};
    @(negedge ref_clk);
    start = 1'b0;
    waitDone(n);
    `CHK(cycleCount, e)
    `CHK(n, int'(e))
  endtask
  task automatic testTwoOp;
    logic [3:0] b [4] = '{4'h1, 4'h2, 4'h2, 4'h3};
    for (int s = 0; s < 4; s++) begin
      run(3'h0, 2'(s), 2'h0, 4'h1, b[s]);
      if (s == 2) `CHK(autoIncNext, autoIncAddr + 16'h2)
      run(3'h0, 2'(s), 2'h3, 4'h1, b[s] + 4'h3);
      run(3'h0, 2'(s), 2'h0, 4'h0, b[s] + {3'h0, s < 3});
    end
    $display("two-operand done");
  endtask
  task automatic testSingle;
    logic [11:0] t [4] = '{12'h134, 12'h344, 12'h345, 12'h455}; // Swap, push, call
    for (int s = 0; s < 4; s++) begin
      for (int c = 1; c < 4; c++) begin
        run(3'(c), 2'(s), 2'(s), 4'h1, t[s][12 - 4 * c +: 4]);
      end
    end
    run(3'h4, 2'h0, 2'h0, 4'h1, 4'h2);
    $display("single-operand done");
  endtask
  task automatic testStack;
    logic [15:0] s0;
    s0 = stack_pointer_reg;
    statusIn = 16'h0a01; // First argument word
    run(3'h2, 2'h0, 2'h0, 4'h1, 4'h3);
    statusIn = 16'h0a02; // Second argument word
    run(3'h2, 2'h0, 2'h0, 4'h1, 4'h3);
    run(3'h3, 2'h0, 2'h0, 4'h1, 4'h4);
    `CHK(stack_pointer_reg, s0 - 16'h6)
    `CHK(mem.m[stack_pointer_reg + 16'h2], 16'h0a02)
    `CHK(mem.m[stack_pointer_reg + 16'h4], 16'h0a01)
    `CHK(mem.m[stack_pointer_reg], nextPc)
    `CHK(pc, branchTarget)
    mem.m[stack_pointer_reg] = 16'h0140; // Skip inline arguments
    run(3'h6, 2'h0, 2'h0, 4'h1, 4'h3);
    `CHK(pc, 16'h0140)
    `CHK(stack_pointer_reg, s0 - 16'h4)
    $display("stack done");
  endtask
  task automatic testIrq(input logic dp);
    logic [15:0] p0, s0;
    int n;
    mem.m[16'hffe2] = 16'h0200;
    mem.m[stack_pointer_reg] = 16'h5a5a; // Top word must survive the entry
    @(negedge ref_clk);
    {p0, s0, deepSleep, irqReq} = {pc, stack_pointer_reg, dp, 1'b1};
    for (n = 0; n < 10 && instrStart !== 1'b1; n++) @(negedge ref_clk);
    irqReq = 1'b0;
    waitDone(n);
    `CHK(n, dp ? 8 : 6)
    `CHK(pc, 16'h0200)
    `CHK(mem.m[s0 - 16'h2], p0)
    `CHK(stack_pointer_reg, s0 - 16'h4)
    `CHK(mem.m[s0], 16'h5a5a)
    deepSleep = 1'b0;
    mem.m[s0 - 16'h4] = 16'h0104; // Status word to come back on return
    run(3'h5, 2'h0, 2'h0, 4'h1, 4'h5);
    `CHK(pc, p0)
    `CHK(stack_pointer_reg, s0)
    `CHK(status_word, 16'h0104)
    $display("interrupt done");
  endtask
  task automatic testIndJump;
    mem.m[pc + 16'h2] = 16'h0300;
    opcode = 16'h4020;
    run(3'h0, 2'h1, 2'h0, 4'h0, 4'h3);
    `CHK(pc, 16'h0300)
    $display("indirect jump done");
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    testTwoOp();
    testSingle();
    testStack();
    testIrq(1'b0);
    testIrq(1'b1);
    testIndJump();
    stopTest();
  end
endmodule // tb
bind cts_sequencer cts_seq_chk chk (
  .ref_clk(ref_clk), .rst(rst), .start(start), .irqReq(irqReq), .deepSleep(deepSleep),
  .busy(busy), .instrStart(instrStart), .memRd(memRd), .memWr(memWr),
  .instrClass(instrClass), .srcMode(srcMode), .dstMode(dstMode), .dstReg(dstReg),
  .cycleCount(cycleCount), .nextPc(nextPc), .statusIn(statusIn), .rdData(rdData),
  .pc(pc), .stack_pointer_reg(stack_pointer_reg), .memAddr(memAddr), .wrData(wrData)
);
`default_nettype wire
